// ---- common/scsd_consts.vh ----
`ifndef SCSD_CONSTS_VH
`define SCSD_CONSTS_VH

// command indices as seen on the card's command interface
`define SCSD_CMD_PROG_CAP     6'd27
`define SCSD_CMD_SET_ADDR     6'd3

// field positions in the 128-bit capability word
`define SCSD_POS_STRUCT_HI    127
`define SCSD_POS_ACCESS_HI    119
`define SCSD_POS_ACCESS_LO    112
`define SCSD_POS_RATE_HI      103
`define SCSD_POS_RATE_LO      96
`define SCSD_POS_CLASS_HI     95
`define SCSD_POS_CLASS_LO     84
`define SCSD_POS_SIZE_HI      69
`define SCSD_POS_SIZE_LO      48
`define SCSD_POS_ERASE1       46
`define SCSD_POS_SECT_HI      45
`define SCSD_POS_SECT_LO      39
`define SCSD_POS_GRP_HI       38
`define SCSD_POS_GRP_LO       32
`define SCSD_POS_FMT_GRP      15
`define SCSD_POS_COPY         14
`define SCSD_POS_PERM_LOCK    13
`define SCSD_POS_TMP_LOCK     12
`define SCSD_POS_FMT_HI       11
`define SCSD_POS_FMT_LO       10
`define SCSD_POS_CRC_HI       7
`define SCSD_POS_CRC_LO       1

// fixed field values
`define SCSD_VAL_STRUCT       2'b01
`define SCSD_VAL_ACCESS       8'b0000_1110
`define SCSD_VAL_NSAC         8'h00
`define SCSD_VAL_RATE         8'b0011_0010
`define SCSD_VAL_CLASS        12'b0101_1011_0101
`define SCSD_VAL_RD_LEN       4'b1001
`define SCSD_VAL_ERASE1       1'b1
`define SCSD_VAL_SECT         7'b111_1111
`define SCSD_VAL_GRP          7'b000_0000
`define SCSD_VAL_R2W          3'b010
`define SCSD_VAL_WR_LEN       4'b1001
`define SCSD_VAL_FMT          2'b00
`define SCSD_VAL_SIZE         22'h00_0000

// reset values
`define SCSD_RST_ADDR         16'h0000
`define SCSD_RST_FLAGS        6'h00

// power-up idle clocks with the command line high
`define SCSD_INIT_CLKS        7'd74

`endif

// ---- design/scsd_crc7.v ----
`timescale 1ns/10ps

// ---------------------------------------------------------------
// serial crc7 step over one bit (polynomial x^7 + x^3 + 1)
// ---------------------------------------------------------------
module scsd_crc7 (
	// state and bit in
	input  wire [6:0] crc_i,
	input  wire       bit_i,
	// next state
	output wire [6:0] crc_o
);

	wire fb;

	// feedback from the top bit
	assign fb    = crc_i[6] ^ bit_i;
	assign crc_o = {crc_i[5:3], crc_i[2] ^ fb, crc_i[1:0], fb};

endmodule

// ---- design/scsd_regs.v ----
`timescale 1ns/10ps
`include "scsd_consts.vh"

module scsd_regs #(
	parameter [21:0] CAP_SIZE = `SCSD_VAL_SIZE
) (
	// clock and reset
	input  wire         sys_clk_i,
	input  wire         arst_n_i,
	// sd link pins, sampled on the system clock
	input  wire         sd_clk_i,
	input  wire         sd_cmd_i,
	// decoded command from the card command engine
	input  wire         cmd_valid_i,
	input  wire [5:0]   cmd_index_i,
	input  wire [127:0] cmd_data_i,
	input  wire [15:0]  addr_new_i,
	// register contents
	output reg  [127:0] card_capability_data_o,
	output reg  [15:0]  relative_card_address_o,
	// status
	output reg          prog_done_o,
	output reg          prog_err_o,
	output reg          link_ready_o
);

	// -----------------------------------------------------------
	// writable state
	// -----------------------------------------------------------
	reg        fmt_grp_r;
	reg        copy_r;
	reg        perm_lock_r;
	reg        temporary_lock_flag_r;
	reg        copy_used_r;
	reg [15:0] relative_card_address_r;

	// -----------------------------------------------------------
	// capability word assembly
	// -----------------------------------------------------------
	wire [127:8] upper;
	wire [6:0]   crc_chain [0:120];
	wire [6:0]   crc_now;

	// fixed fields are wired constants, so no write can reach them
	assign upper = {
		`SCSD_VAL_STRUCT,
		6'h00,
		`SCSD_VAL_ACCESS,
		`SCSD_VAL_NSAC,
		`SCSD_VAL_RATE,
		`SCSD_VAL_CLASS,
		`SCSD_VAL_RD_LEN,
		3'b000,                                         // no partial reads
		1'b0,
		6'h00,
		CAP_SIZE,
		1'b0,
		`SCSD_VAL_ERASE1,
		`SCSD_VAL_SECT,
		`SCSD_VAL_GRP,
		1'b0,                                           // no group protect
		2'b00,
		`SCSD_VAL_R2W,
		`SCSD_VAL_WR_LEN,
		1'b0,
		5'h00,
		fmt_grp_r,
		copy_r,
		perm_lock_r,
		temporary_lock_flag_r,
		`SCSD_VAL_FMT,
		2'b00
	};

	// crc7 chain over bits 127..8, msb first
	// one step module per bit; the chain is long but only feeds a flop
	assign crc_chain[0] = 7'h00;
	genvar gi;
	generate
		for (gi = 0; gi < 120; gi = gi + 1) begin : g_crc
			scsd_crc7 u_step (
				.crc_i (crc_chain[gi]),
				.bit_i (upper[127 - gi]),
				.crc_o (crc_chain[gi + 1])
			);
		end
	endgenerate
	assign crc_now = crc_chain[120];

	// -----------------------------------------------------------
	// link pin synchronisers and idle clock counter
	// -----------------------------------------------------------
	reg  [1:0] clk_sync_r;
	reg  [1:0] cmd_sync_r;
	reg        clk_prev_r;
	reg  [6:0] init_cnt_r;
	reg  [6:0] init_cnt_nxt;
	wire       clk_rise;

	assign clk_rise = clk_sync_r[1] & ~clk_prev_r;

	// two flops per pin before any use
	// only the second flop of each pair is read by logic
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clk_sync_r <= 2'b00;
			cmd_sync_r <= 2'b11;
			clk_prev_r <= 1'b0;
		end else begin
			clk_sync_r <= {clk_sync_r[0], sd_clk_i};
			cmd_sync_r <= {cmd_sync_r[0], sd_cmd_i};
			clk_prev_r <= clk_sync_r[1];
		end
	end

	// counts link clocks with command high; a low restarts the count
	// saturates at the target so link ready can never fall again
	always @* begin
		init_cnt_nxt = init_cnt_r;
		if (!cmd_sync_r[1] && init_cnt_r != `SCSD_INIT_CLKS)
			init_cnt_nxt = 7'd0;
		else if (clk_rise && init_cnt_r != `SCSD_INIT_CLKS)
			init_cnt_nxt = init_cnt_r + 7'd1;
	end

	// -----------------------------------------------------------
	// command handling
	// -----------------------------------------------------------
	wire is_prog;
	wire is_addr;
	wire copy_bad;
	wire fixed_bad;
	wire [127:0] fixed_mask;

	// writable positions: 15..12 and crc 7..1; format bits stay fixed
	assign fixed_mask = ~{112'h0, 4'hf, 4'h0, 7'h7f, 1'b0};

	// commands before link ready are dropped without any answer
	assign is_prog  = cmd_valid_i && link_ready_o &&
	                  cmd_index_i == `SCSD_CMD_PROG_CAP;
	assign is_addr  = cmd_valid_i && link_ready_o &&
	                  cmd_index_i == `SCSD_CMD_SET_ADDR;
	// a fixed field that differs means the host tried to change it
	// limitation: the word on the outputs trails a program by one
	// cycle, so a second program in the next cycle is judged against the old word
	assign fixed_bad = |((cmd_data_i ^ card_capability_data_o) &
	                     fixed_mask);
	// once used, the copy flag may not change again
	// it counts as used even when the first program wrote zero
	assign copy_bad = copy_used_r &&
	                  cmd_data_i[`SCSD_POS_COPY] != copy_r;
	// the crc bits of a program are ignored: the word always carries
	// a checksum freshly worked out from its upper bits

	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fmt_grp_r               <= 1'b0;
			copy_r                  <= 1'b0;
			perm_lock_r             <= 1'b0;
			temporary_lock_flag_r   <= 1'b0;
			copy_used_r             <= 1'b0;
			relative_card_address_r <= `SCSD_RST_ADDR;
			init_cnt_r              <= 7'd0;
			prog_done_o             <= 1'b0;
			prog_err_o              <= 1'b0;
			link_ready_o            <= 1'b0;
			relative_card_address_o <= `SCSD_RST_ADDR;
			// the word reads zero until the first edge after release
			card_capability_data_o  <= 128'h0;
		end else begin
			init_cnt_r   <= init_cnt_nxt;
			// first command accepted only after the idle clocks
			link_ready_o <= (init_cnt_nxt == `SCSD_INIT_CLKS);
			prog_done_o  <= 1'b0;
			prog_err_o   <= 1'b0;
			if (is_prog) begin
				if (fixed_bad || copy_bad) begin
					prog_err_o <= 1'b1;
				end else begin
					fmt_grp_r   <= cmd_data_i[`SCSD_POS_FMT_GRP];
					copy_r      <= cmd_data_i[`SCSD_POS_COPY];
					copy_used_r <= 1'b1;
					perm_lock_r <= cmd_data_i[`SCSD_POS_PERM_LOCK];
					temporary_lock_flag_r <=
						cmd_data_i[`SCSD_POS_TMP_LOCK];
					prog_done_o <= 1'b1;
				end
			end
			if (is_addr)
				relative_card_address_r <= addr_new_i;
			relative_card_address_o <= is_addr ? addr_new_i :
			                           relative_card_address_r;
			// crc refreshed every cycle; bit zero held at one
			card_capability_data_o <= {upper, crc_now, 1'b1};
		end
	end

	// no driver stage register exists here
	// bit 76 of the word reads zero to tell the host so
	// host duties on erase use and power are outside this logic

endmodule

// ---- testbench/scsd_host_model.sv ----
`timescale 1ns/10ps

// host side: lines low while unpowered, then a burst of init clocks
// the clock stands still after the burst, as outside any frame
module scsd_host_model (
	input  wire start_i,
	output reg  sd_clk_o,
	output reg  sd_cmd_o
);
	integer n;
	initial begin
		sd_clk_o = 1'b0;
		sd_cmd_o = 1'b0;
		forever begin
			wait (start_i === 1'b1);
			#37 sd_cmd_o = 1'b1;
			for (n = 0; n < 80; n = n + 1) begin
				#100 sd_clk_o = 1'b1;
				#100 sd_clk_o = 1'b0;
			end
			// power removed: nothing may feed the card's pins
			wait (start_i === 1'b0);
			sd_cmd_o = 1'b0;
		end
	end
endmodule

// ---- testbench/scsd_regs_asserts.sv ----
`timescale 1ns/10ps
`include "scsd_consts.vh"

module scsd_regs_asserts #(
	parameter [21:0] CAP_SIZE = 22'h00_0000
) (
	input wire         sys_clk_i,
	input wire         arst_n_i,
	input wire         sd_clk_i,
	input wire         sd_cmd_i,
	input wire         cmd_valid_i,
	input wire [5:0]   cmd_index_i,
	input wire [127:0] cmd_data_i,
	input wire [15:0]  addr_new_i,
	input wire [127:0] card_capability_data_o,
	input wire [15:0]  relative_card_address_o,
	input wire         prog_done_o,
	input wire         prog_err_o,
	input wire         link_ready_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	wire [127:0] w = card_capability_data_o;
	a_answer_cause:
	assert property ((prog_done_o || prog_err_o) |-> $past(cmd_valid_i
		&& cmd_index_i == `SCSD_CMD_PROG_CAP && link_ready_o))
		else $error("program answer without a program");
	a_word_hold:
	assert property ($past(arst_n_i) && $past(arst_n_i, 2) &&
		!$past(prog_done_o) |-> $stable(w))
		else $error("word changed without accepted program");
	a_err_keeps:
	assert property (prog_err_o |=> $stable(w))
		else $error("refused program changed word");
	a_access_code:
	assert property ($past(arst_n_i) |-> w[119:112] == `SCSD_VAL_ACCESS)
		else $error("access time code wrong");
	a_fixed_fields:
	assert property ($past(arst_n_i) |-> w[103:96] == `SCSD_VAL_RATE
		&& w[95:84] == `SCSD_VAL_CLASS && w[45:32] == 14'h3f80
		&& w[46] && w[0])
		else $error("fixed field wrong");
	a_format_fixed:
	assert property ($past(arst_n_i) |-> w[11:10] == `SCSD_VAL_FMT
		&& !w[76])
		else $error("format or driver stage bit wrong");
	a_capacity:
	assert property ($past(arst_n_i) |-> w[69:48] == CAP_SIZE)
		else $error("capacity wrong");
	a_addr_load:
	assert property (cmd_valid_i && cmd_index_i == `SCSD_CMD_SET_ADDR &&
		link_ready_o |=> relative_card_address_o == $past(addr_new_i))
		else $error("address not loaded");
	a_ready_holds:
	assert property (link_ready_o |=> link_ready_o)
		else $error("link ready dropped");
	a_ignore_early:
	assert property (!link_ready_o |=> !prog_done_o && !prog_err_o)
		else $error("command taken before ready");
endmodule

bind scsd_regs scsd_regs_asserts #(.CAP_SIZE(CAP_SIZE)) chk_i (.*);

// ---- testbench/scsd_regs_test.sv ----
`timescale 1ns/10ps
`include "scsd_consts.vh"

module scsd_regs_test;
	localparam [21:0] SZ = 22'h2a_5c3d;
	reg          sys_clk_i, arst_n_i, vld, start;
	reg  [5:0]   idx;
	reg  [127:0] dat, w, old;
	reg  [15:0]  an;
	reg  [31:0]  r;
	wire         sclk, scmd, done, err, rdy;
	wire [127:0] cap;
	wire [15:0]  relative_card_address;
	integer      err_count, check_count, cyc, seed, i;
	reg  [1:0]   q[$];
	scsd_host_model host (.start_i(start), .sd_clk_o(sclk), .sd_cmd_o(scmd));
	scsd_regs #(.CAP_SIZE(SZ)) DUT (.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i), .sd_clk_i(sclk), .sd_cmd_i(scmd),
		.cmd_valid_i(vld), .cmd_index_i(idx), .cmd_data_i(dat),
		.addr_new_i(an), .card_capability_data_o(cap),
		.relative_card_address_o(relative_card_address), .prog_done_o(done),
		.prog_err_o(err), .link_ready_o(rdy));
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	task chk(input [127:0] s, input [127:0] e, input [79:0] nm);
		check_count = check_count + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("MISMATCH %0s exp %h got %h", nm, e, s);
		end
	endtask
	// checksum of the upper bits, polynomial x^7 + x^3 + 1
	function [6:0] crc7(input [127:0] v);
		integer k;
		reg     fb;
		begin
			crc7 = 7'h00;
			for (k = 127; k >= 8; k = k - 1) begin
				fb = crc7[6] ^ v[k];
				crc7 = {crc7[5:0], 1'b0} ^ {3'b000, fb, 2'b00, fb};
			end
		end
	endfunction
	task test_done;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one command; note expected {done,err}, 0 when it must be ignored
	task cmd(input [5:0] i, input [127:0] d, input [1:0] e);
		@(negedge sys_clk_i);
		vld = 1'b1; idx = i; dat = d;
		if (e != 2'b00) q.push_back(e);
		@(negedge sys_clk_i) vld = 1'b0;
		repeat (3) @(negedge sys_clk_i);
	endtask
	// answers are taken off the queue oldest first
	always @(negedge sys_clk_i)
		if (done === 1'b1 || err === 1'b1) begin
			if (q.size() == 0) chk(2'b11, 2'b00, "spurious");
			else chk({done, err}, q.pop_front(), "answer");
		end
	// hang guard: two init bursts, the 1 ms off time and the tests
	always @(posedge sys_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 50_000) begin
			err_count = err_count + 1;
			test_done;
		end
	end
	initial begin
		seed = 32'h0000_1c16; err_count = 0; check_count = 0; cyc = 0;
		arst_n_i = 1'b0; vld = 1'b0; start = 1'b0;
		idx = 6'h00; dat = 128'h0; an = 16'h0000;
		repeat (3) @(negedge sys_clk_i);
		arst_n_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		chk(cap[127:126], `SCSD_VAL_STRUCT, "struct");
		chk(cap[119:112], `SCSD_VAL_ACCESS, "access");
		chk(cap[103:96], `SCSD_VAL_RATE, "rate");
		chk(cap[95:84], `SCSD_VAL_CLASS, "class");
		chk(cap[69:48], SZ, "capacity");
		chk(cap[45:39], `SCSD_VAL_SECT, "sector");
		chk(cap[38:32], `SCSD_VAL_GRP, "group");
		chk(cap[46], `SCSD_VAL_ERASE1, "erase1");
		chk({cap[15:8], cap[0]}, 9'h001, "flags");
		chk(relative_card_address, `SCSD_RST_ADDR, "addr_rst");
		chk(rdy, 1'b0, "ready_rst");
		chk(cap[76], 1'b0, "no_dsr");
		chk(cap[7:1], crc7(cap), "crc_rst");
		$display("test reset values done");
		old = cap; an = 16'h5a5a;
		cmd(`SCSD_CMD_PROG_CAP, ~old, 2'b00);
		cmd(`SCSD_CMD_SET_ADDR, 128'h0, 2'b00);
		chk(cap, old, "early_prog");
		chk(relative_card_address, `SCSD_RST_ADDR, "early_addr");
		$display("test early commands done");
		start = 1'b1;
		wait (rdy === 1'b1);
		r = $random(seed); w = cap; w[15:12] = r[3:0];
		cmd(`SCSD_CMD_PROG_CAP, w, 2'b10);
		chk(cap[127:8], w[127:8], "prog");
		chk(cap[0], 1'b1, "bit0");
		chk(cap[7:1], crc7(cap), "crc");
		old = cap; w = cap; w[14] = ~w[14];
		cmd(`SCSD_CMD_PROG_CAP, w, 2'b01);
		chk(cap, old, "copy_again");
		w = cap; w[12] = ~w[12];
		cmd(`SCSD_CMD_PROG_CAP, w, 2'b10);
		chk(cap[12], w[12], "lock_flag");
		old = cap;
		w = cap;
		w[11] = ~w[11];
		cmd(`SCSD_CMD_PROG_CAP, w, 2'b01);
		chk(cap, old, "format");
		$display("test program done");
		for (i = 0; i < 6; i = i + 1) begin
			old = cap; w = cap; r = $random(seed);
			w[16 + r[6:0] % 112] = ~w[16 + r[6:0] % 112];
			cmd(`SCSD_CMD_PROG_CAP, w, 2'b01);
			chk(cap, old, "fixed_bit");
			r = $random(seed); an = r[15:0];
			cmd(`SCSD_CMD_SET_ADDR, 128'h0, 2'b00);
			chk(relative_card_address, an, "addr");
		end
		$display("test refusals and address done");
		// power cycle: reset held and host lines low the whole time
		@(negedge sys_clk_i);
		start = 1'b0;
		arst_n_i = 1'b0;
		repeat (40_000) @(negedge sys_clk_i);
		arst_n_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		chk(rdy, 1'b0, "ready_pwr");
		chk({cap[15:8], cap[0]}, 9'h001, "flags_pwr");
		chk(relative_card_address, `SCSD_RST_ADDR, "addr_pwr");
		start = 1'b1;
		wait (rdy === 1'b1);
		@(negedge sys_clk_i);
		r = $random(seed);
		an = r[15:0];
		cmd(`SCSD_CMD_SET_ADDR, 128'h0, 2'b00);
		chk(relative_card_address, an, "addr_pwr2");
		chk(cap[7:1], crc7(cap), "crc_pwr");
		$display("test power cycle done");
		chk(q.size(), 0, "queue");
		test_done;
	end
endmodule
